// *** hdl/rss_glitch_filter.sv ***
// Passes a high level only once it has held for a least number of cycles; a low level passes at once
module rss_glitch_filter #(
	parameter int CYCLES = 4
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic raw,
	output logic clean
);
	localparam int W = $clog2(CYCLES + 1);
	localparam logic [W-1:0] LIMIT = W'(CYCLES);

	if (CYCLES < 1) begin : g_chk
		$error("rss_glitch_filter: CYCLES must be at least 1");
	end

	logic [W-1:0] count;
	wire held = (count == LIMIT);

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			count <= '0;
			clean <= 1'b0;
		end else begin
			count <= !raw ? '0 : (held ? count : count + W'(1));
			clean <= raw && held;
		end
	end
endmodule

// *** hdl/rss_pkg.sv ***
// Types of the reset source and time-out sequencer
package rss_pkg;
	typedef enum logic [2:0] {
		RSS_CAUSE_NONE,
		RSS_CAUSE_POWER_ON,
		RSS_CAUSE_BROWN_OUT,
		RSS_CAUSE_WDT_RUN,
		RSS_CAUSE_WDT_SLEEP,
		RSS_CAUSE_PIN_RUN,
		RSS_CAUSE_PIN_SLEEP
	} rss_cause_t;

	typedef enum logic [1:0] {
		RSS_SEQ_HOLD,
		RSS_SEQ_POWER_UP_TIMER,
		RSS_SEQ_OST,
		RSS_SEQ_RUN
	} rss_seq_t;
endpackage

// *** hdl/rss_regs.svh ***
// Constants of the reset source and time-out sequencer
`ifndef RSS_REGS_SVH
`define RSS_REGS_SVH

// System clock
`define RSS_CLK_MHZ 40

// Power-up timer: nominal time and the low-frequency oscillator that times it
`define RSS_POWER_UP_TIMER_TIME_MS 64
`define RSS_LF_OSC_HZ 31000
`define RSS_POWER_UP_TIMER_LF_CYCLES ((`RSS_POWER_UP_TIMER_TIME_MS * `RSS_LF_OSC_HZ) / 1000)

// Oscillator start-up timer, in oscillator cycles
`define RSS_OST_OSC_CYCLES 1024

// Reset pin glitch filter: least pulse width that resets
`define RSS_PIN_FILT_NS 2000
`define RSS_PIN_FILT_CYCLES ((`RSS_PIN_FILT_NS * `RSS_CLK_MHZ + 999) / 1000)

// Least brown-out duration that resets
`define RSS_BOR_MIN_NS 100
`define RSS_BOR_MIN_CYCLES ((`RSS_BOR_MIN_NS * `RSS_CLK_MHZ + 999) / 1000)

// Fuse encodings
`define RSS_PIN_IS_RESET 1'b1
`define RSS_POWER_UP_TIMER_FUSE_ON 1'b0
`define RSS_BOR_MODE_ALWAYS 2'b11
`define RSS_BOR_MODE_RUN_ONLY 2'b10
`define RSS_BOR_MODE_SOFT 2'b01
`define RSS_BOR_MODE_OFF 2'b00

// Reset values
`define RSS_SOFT_BROWN_OUT_ENABLE_RESET 1'b1
`define RSS_POR_FLAG_RESET 1'b0
`define RSS_BOR_FLAG_RESET 1'b0
`define RSS_TO_FLAG_RESET 1'b1
`define RSS_PD_FLAG_RESET 1'b1
`define RSS_CTRL_RESET 8'h00

`endif

// *** hdl/rss_reset_sequencer.sv ***
// Reset source merge, start-up time-out sequencer and reset status flags
//
// Contract
// - Keep the six reset causes apart
// - Defined registers load on resets, not WDT wake
// - Retained registers are never initialised
// - Reset pin filter rejects short glitches
// - Watchdog reset never drives the pin
// - Pin fuse selects reset input or digital input
// - Internal reset option leaves programming mode alone
// - Power-up timer runs only after power-on or brown-out
// - Power-up timer counts low-frequency oscillator ticks
// - Chip held in reset while power-up timer runs
// - Power-up timer fuse 1 bypasses, 0 uses
// - Mode 01: software bit gates brown-out
// - Mode 10: brown-out off in sleep, bit ignored
// - Mode fuses: 11 on, 10 run, 01 soft, 00 off
// - Brown-out resets only after minimum duration
// - Stay in reset until supply recovers, then timer
// - Brown-out during timer restarts it fully
// - Power-on, then power-up timer, then start-up timer
// - External clock without timer: no time-out
// - Time-outs run from power-on regardless of pin
// - Two-speed or fail-safe runs code during start-up timer
// - Power-on flag cleared by power-on only
`include "rss_regs.svh"

module rss_reset_sequencer
	import rss_pkg::*;
#(
	parameter int POWER_UP_TIMER_LF_CYCLES = `RSS_POWER_UP_TIMER_LF_CYCLES,
	parameter int OST_OSC_CYCLES = `RSS_OST_OSC_CYCLES,
	parameter int PIN_FILT_CYCLES = `RSS_PIN_FILT_CYCLES,
	parameter int BOR_MIN_CYCLES = `RSS_BOR_MIN_CYCLES
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic power_on_detect,
	input wire logic supply_below_threshold,
	input wire logic master_clear_pin_in,
	output logic master_clear_pin_out,
	output logic master_clear_pin_oe,
	input wire logic reset_pin_select_fuse,
	input wire logic power_up_timer_fuse,
	input wire logic [1:0] brown_out_mode_fuses,
	input wire logic external_clock_mode,
	input wire logic two_speed_fuse,
	input wire logic fail_safe_fuse,
	input wire logic lf_osc_tick,
	input wire logic osc_cycle_tick,
	input wire logic sleep_active,
	input wire logic watchdog_timer_fire,
	input wire logic sleep_cmd,
	input wire logic clear_wdt_cmd,
	input wire logic soft_brown_out_wr,
	input wire logic soft_brown_out_wdata,
	input wire logic power_on_flag_set,
	input wire logic brown_out_flag_set,
	input wire logic prog_mode_req,
	input wire logic ctrl_wr,
	input wire logic [7:0] ctrl_wdata,
	input wire logic retain_wr,
	input wire logic [7:0] retain_wdata,
	output logic chip_reset,
	output logic cpu_run,
	output logic wdt_wake,
	output logic pin_digital_in,
	output logic pin_pullup_en,
	output logic brown_out_detect_en,
	output logic soft_brown_out_enable,
	output logic power_on_flag,
	output logic brown_out_flag,
	output logic timeout_flag,
	output logic power_down_flag,
	output rss_cause_t reset_cause,
	output rss_seq_t seq_state,
	output logic prog_mode,
	output logic [7:0] ctrl_q,
	output logic [7:0] retain_q
);
	rss_seq_t state;
	rss_seq_t next_state;
	rss_timer_if power_up_timer_if ();
	rss_timer_if ost_if ();

	// Pin role and glitch filter
	wire pin_is_reset = (reset_pin_select_fuse == `RSS_PIN_IS_RESET);
	wire pin_low_raw = pin_is_reset && !master_clear_pin_in;
	logic pin_reset;
	logic pin_reset_d;

	rss_glitch_filter #(
		.CYCLES(PIN_FILT_CYCLES)
	) u_pin_filter (
		.clk(clk),
		.rst_b(rst_b),
		.raw(pin_low_raw),
		.clean(pin_reset)
	);

	wire pin_event = pin_reset && !pin_reset_d;

	// Brown-out enable decode
	wire mode_always = (brown_out_mode_fuses == `RSS_BOR_MODE_ALWAYS);
	wire mode_run = (brown_out_mode_fuses == `RSS_BOR_MODE_RUN_ONLY);
	wire mode_soft = (brown_out_mode_fuses == `RSS_BOR_MODE_SOFT);
	wire bor_run_en = mode_run && !sleep_active;
	wire bor_soft_en = mode_soft && soft_brown_out_enable;
	wire bor_en = mode_always || bor_run_en || bor_soft_en;
	wire bor_low_raw = bor_en && supply_below_threshold;
	logic bor_trip;

	rss_glitch_filter #(
		.CYCLES(BOR_MIN_CYCLES)
	) u_bor_filter (
		.clk(clk),
		.rst_b(rst_b),
		.raw(bor_low_raw),
		.clean(bor_trip)
	);

	// A brown-out event restarts the sequence; a raw dip alone only holds it
	wire bor_event = bor_trip && state != RSS_SEQ_HOLD;
	wire por_event = power_on_detect;
	wire hold_cond = power_on_detect || bor_low_raw;

	// Watchdog: wake in sleep, reset while running
	wire wdt_reset_event = watchdog_timer_fire && !sleep_active;
	wire wdt_wake_event = watchdog_timer_fire && sleep_active;

	// Start-up timers
	wire power_up_timer_used = (power_up_timer_fuse == `RSS_POWER_UP_TIMER_FUSE_ON);
	wire ost_used = !external_clock_mode;
	wire early_run = two_speed_fuse || fail_safe_fuse;

	assign power_up_timer_if.clear = (state != RSS_SEQ_POWER_UP_TIMER);
	assign power_up_timer_if.tick = lf_osc_tick;
	assign ost_if.clear = (state != RSS_SEQ_OST);
	assign ost_if.tick = osc_cycle_tick;

	rss_tick_timer #(
		.LIMIT(POWER_UP_TIMER_LF_CYCLES)
	) u_power_up_timer (
		.clk(clk),
		.rst_b(rst_b),
		.tif(power_up_timer_if.tmr)
	);

	rss_tick_timer #(
		.LIMIT(OST_OSC_CYCLES)
	) u_ost (
		.clk(clk),
		.rst_b(rst_b),
		.tif(ost_if.tmr)
	);

	// Sequence: only power-on and brown-out enter the hold state,
	// so pin and watchdog resets never rerun the timers
	always_comb begin
		next_state = state;
		case (state)
			RSS_SEQ_HOLD: begin
				if (!hold_cond) begin
					if (power_up_timer_used) begin
						next_state = RSS_SEQ_POWER_UP_TIMER;
					end else if (ost_used) begin
						next_state = RSS_SEQ_OST;
					end else begin
						next_state = RSS_SEQ_RUN;
					end
				end
			end
			RSS_SEQ_POWER_UP_TIMER: begin
				if (por_event || bor_event) begin
					next_state = RSS_SEQ_HOLD;
				end else if (power_up_timer_if.done) begin
					next_state = ost_used ? RSS_SEQ_OST : RSS_SEQ_RUN;
				end
			end
			RSS_SEQ_OST: begin
				if (por_event || bor_event) begin
					next_state = RSS_SEQ_HOLD;
				end else if (ost_if.done) begin
					next_state = RSS_SEQ_RUN;
				end
			end
			RSS_SEQ_RUN: begin
				if (por_event || bor_event) begin
					next_state = RSS_SEQ_HOLD;
				end
			end
			default: begin
				next_state = RSS_SEQ_HOLD;
			end
		endcase
	end

	// Merged reset: the sequence and the pin run independently, so a pin
	// held past the time-outs releases the chip at once
	wire seq_busy = (next_state != RSS_SEQ_RUN) &&
		!(next_state == RSS_SEQ_OST && early_run);
	wire next_chip_reset = seq_busy || pin_reset || wdt_reset_event;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state <= RSS_SEQ_HOLD;
			chip_reset <= 1'b1;
			pin_reset_d <= 1'b0;
			wdt_wake <= 1'b0;
		end else begin
			state <= next_state;
			chip_reset <= next_chip_reset;
			pin_reset_d <= pin_reset;
			wdt_wake <= wdt_wake_event;
		end
	end

	assign cpu_run = !chip_reset;
	assign seq_state = state;

	// Pin drive: the watchdog reset stays inside the chip
	assign master_clear_pin_out = 1'b0;
	assign master_clear_pin_oe = 1'b0;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pin_digital_in <= 1'b0;
			pin_pullup_en <= 1'b0;
			brown_out_detect_en <= 1'b0;
			prog_mode <= 1'b0;
		end else begin
			pin_digital_in <= !pin_is_reset && master_clear_pin_in;
			pin_pullup_en <= pin_is_reset;
			brown_out_detect_en <= bor_en;
			prog_mode <= prog_mode_req;
		end
	end

	// Cause of the last reset or wake
	rss_cause_t next_cause;

	always_comb begin
		next_cause = reset_cause;
		if (por_event) begin
			next_cause = RSS_CAUSE_POWER_ON;
		end else if (bor_event) begin
			next_cause = RSS_CAUSE_BROWN_OUT;
		end else if (wdt_reset_event) begin
			next_cause = RSS_CAUSE_WDT_RUN;
		end else if (wdt_wake_event) begin
			next_cause = RSS_CAUSE_WDT_SLEEP;
		end else if (pin_event && sleep_active) begin
			next_cause = RSS_CAUSE_PIN_SLEEP;
		end else if (pin_event) begin
			next_cause = RSS_CAUSE_PIN_RUN;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			reset_cause <= RSS_CAUSE_POWER_ON;
		end else begin
			reset_cause <= next_cause;
		end
	end

	// Timeout and power-down flags
	logic next_to;
	logic next_pd;

	always_comb begin
		next_to = timeout_flag;
		next_pd = power_down_flag;
		if (por_event || bor_event) begin
			next_to = 1'b1;
			next_pd = 1'b1;
		end else if (wdt_reset_event) begin
			next_to = 1'b0;
		end else if (wdt_wake_event) begin
			next_to = 1'b0;
			next_pd = 1'b0;
		end else if (pin_event && sleep_active) begin
			next_to = 1'b1;
			next_pd = 1'b0;
		end else if (sleep_cmd) begin
			next_to = 1'b1;
			next_pd = 1'b0;
		end else if (clear_wdt_cmd) begin
			next_to = 1'b1;
			next_pd = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			timeout_flag <= `RSS_TO_FLAG_RESET;
			power_down_flag <= `RSS_PD_FLAG_RESET;
		end else begin
			timeout_flag <= next_to;
			power_down_flag <= next_pd;
		end
	end

	// Power control bits; a hardware clear outranks a software set
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			power_on_flag <= `RSS_POR_FLAG_RESET;
			brown_out_flag <= `RSS_BOR_FLAG_RESET;
			soft_brown_out_enable <= `RSS_SOFT_BROWN_OUT_ENABLE_RESET;
		end else begin
			if (por_event) begin
				power_on_flag <= 1'b0;
			end else if (power_on_flag_set) begin
				power_on_flag <= 1'b1;
			end
			if (bor_event) begin
				brown_out_flag <= 1'b0;
			end else if (brown_out_flag_set) begin
				brown_out_flag <= 1'b1;
			end
			if (por_event || bor_event) begin
				soft_brown_out_enable <= `RSS_SOFT_BROWN_OUT_ENABLE_RESET;
			end else if (soft_brown_out_wr) begin
				soft_brown_out_enable <= soft_brown_out_wdata;
			end
		end
	end

	// Register with a defined reset state: loaded on every chip reset,
	// untouched by a watchdog wake since that raises no chip reset
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ctrl_q <= `RSS_CTRL_RESET;
		end else if (chip_reset) begin
			ctrl_q <= `RSS_CTRL_RESET;
		end else if (ctrl_wr) begin
			ctrl_q <= ctrl_wdata;
		end
	end

	// Retained register: no reset of any kind
	always_ff @(posedge clk) begin
		if (retain_wr) begin
			retain_q <= retain_wdata;
		end
	end
endmodule

// *** hdl/rss_tick_timer.sv ***
// Counts ticks up to a limit while not cleared
module rss_tick_timer #(
	parameter int LIMIT = 1024
) (
	input wire logic clk,
	input wire logic rst_b,
	rss_timer_if.tmr tif
);
	localparam int W = $clog2(LIMIT + 1);
	localparam logic [W-1:0] TOP = W'(LIMIT);

	if (LIMIT < 1) begin : g_chk
		$error("rss_tick_timer: LIMIT must be at least 1");
	end

	logic [W-1:0] count;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			count <= '0;
		end else if (tif.clear) begin
			count <= '0;
		end else if (tif.tick && count != TOP) begin
			count <= count + W'(1);
		end
	end

	assign tif.done = (count == TOP);
endmodule

// *** hdl/rss_timer_if.sv ***
// Control and status of one start-up timer
interface rss_timer_if;
	logic clear;
	logic tick;
	logic done;
	modport ctl (output clear, output tick, input done);
	modport tmr (input clear, input tick, output done);
endinterface

// *** tb/rss_reset_sequencer_sva.sv ***
// Port checker of the reset source and time-out sequencer
module rss_reset_sequencer_sva
	import rss_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic power_on_detect,
	input wire logic master_clear_pin_oe,
	input wire logic reset_pin_select_fuse,
	input wire logic power_up_timer_fuse,
	input wire logic [1:0] brown_out_mode_fuses,
	input wire logic two_speed_fuse,
	input wire logic fail_safe_fuse,
	input wire logic sleep_active,
	input wire logic watchdog_timer_fire,
	input wire logic chip_reset,
	input wire logic cpu_run,
	input wire logic wdt_wake,
	input wire logic pin_pullup_en,
	input wire logic brown_out_detect_en,
	input wire logic power_on_flag,
	input wire logic timeout_flag,
	input wire logic power_down_flag,
	input wire rss_cause_t reset_cause,
	input wire rss_seq_t seq_state
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	sequence s_hold_exit;
		seq_state == RSS_SEQ_HOLD ##1 seq_state != RSS_SEQ_HOLD;
	endsequence
	sequence s_wdt_run;
		cpu_run && !sleep_active && watchdog_timer_fire;
	endsequence
	sequence s_wdt_sleep;
		cpu_run && sleep_active && watchdog_timer_fire;
	endsequence
	a_pin_not_driven: assert property (!master_clear_pin_oe)
		else $error("reset pin driven");
	a_pullup_fuse: assert property ($past(rst_b) |-> pin_pullup_en == $past(reset_pin_select_fuse))
		else $error("pull-up not per fuse");
	a_wdt_reset: assert property (s_wdt_run |=> chip_reset && reset_cause == RSS_CAUSE_WDT_RUN
		&& !timeout_flag ##1 !chip_reset)
		else $error("watchdog reset wrong");
	a_wdt_wake: assert property (s_wdt_sleep |=> wdt_wake && !chip_reset && !timeout_flag
		&& !power_down_flag && reset_cause == RSS_CAUSE_WDT_SLEEP)
		else $error("watchdog wake wrong");
	a_hold_exit: assert property (s_hold_exit |-> !$past(power_on_detect))
		else $error("left hold during power-on");
	a_timer_fuse: assert property (s_hold_exit |->
		(seq_state == RSS_SEQ_POWER_UP_TIMER) == !$past(power_up_timer_fuse))
		else $error("timer fuse ignored");
	a_power_up_timer_holds: assert property (seq_state == RSS_SEQ_POWER_UP_TIMER |-> chip_reset)
		else $error("released during timer");
	a_release_late: assert property (!chip_reset |-> seq_state == RSS_SEQ_RUN
		|| (seq_state == RSS_SEQ_OST && (two_speed_fuse || fail_safe_fuse)))
		else $error("released too early");
	a_bor_off: assert property ($past(brown_out_mode_fuses) == 2'h0 |-> !brown_out_detect_en)
		else $error("brown-out on in mode 00");
	a_bor_on: assert property ($past(rst_b) && $past(brown_out_mode_fuses) == 2'h3
		|-> brown_out_detect_en)
		else $error("brown-out off in mode 11");
	a_bor_sleep: assert property ($past(rst_b) && $past(brown_out_mode_fuses) == 2'h2
		|-> brown_out_detect_en == !$past(sleep_active))
		else $error("brown-out sleep gating wrong");
	a_por_flag: assert property (power_on_detect |=> !power_on_flag)
		else $error("power-on flag not cleared");
endmodule

bind rss_reset_sequencer rss_reset_sequencer_sva u_rss_reset_sequencer_sva (.*);

// *** tb/testbench.sv ***
// Self-checking bench of the reset source and time-out sequencer
module testbench
	import rss_pkg::*;
();
	timeunit 1ns;
	timeprecision 1ps;
	localparam int PW = 8;
	localparam int OS = 4;
	localparam int PF = 3;
	logic clk, rst_b, power_on_detect, supply_below_threshold, master_clear_pin_in;
	logic reset_pin_select_fuse, power_up_timer_fuse, external_clock_mode, two_speed_fuse;
	logic fail_safe_fuse, lf_osc_tick, osc_cycle_tick, sleep_active, watchdog_timer_fire;
	logic sleep_cmd, clear_wdt_cmd, soft_brown_out_wr, soft_brown_out_wdata, prog_mode;
	logic power_on_flag_set, brown_out_flag_set, prog_mode_req, ctrl_wr, retain_wr;
	logic master_clear_pin_out, master_clear_pin_oe, chip_reset, cpu_run, wdt_wake;
	logic pin_digital_in, pin_pullup_en, brown_out_detect_en, soft_brown_out_enable;
	logic power_on_flag, brown_out_flag, timeout_flag, power_down_flag;
	logic [1:0] brown_out_mode_fuses;
	logic [3:0] ph = 4'h0;
	logic [7:0] ctrl_wdata, retain_wdata, ctrl_q, retain_q;
	rss_cause_t reset_cause;
	rss_seq_t seq_state;
	int miscompares, tests_run, seed, n;

	rss_reset_sequencer #(.POWER_UP_TIMER_LF_CYCLES(PW), .OST_OSC_CYCLES(OS), .PIN_FILT_CYCLES(PF),
		.BOR_MIN_CYCLES(2)) u_rss_reset_sequencer (.*);

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// Slow oscillator every 4 cycles, main oscillator every 2
	always @(posedge clk) begin
		ph <= ph + 4'h1;
		lf_osc_tick <= ph[1:0] == 2'h3;
		osc_cycle_tick <= ph[0];
	end

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wt(input bit r, input rss_seq_t s);
		n = 0;
		while ((r ? cpu_run !== 1'b1 : seq_state !== s) && n < 300) begin
			@(negedge clk);
			n++;
		end
		if (n >= 300) miscompares++;
	endtask

	function automatic logic eb(input logic [1:0] m, input logic s, input logic z);
		return m == 2'h3 || (m == 2'h2 && !z) || (m == 2'h1 && s);
	endfunction

	task automatic summarize();
		$display("miscompares %0d tests_run %0d", miscompares, tests_run);
		if (miscompares == 0 && tests_run > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	initial begin
		#100000;
		miscompares++;
		summarize();
	end

	initial begin
		seed = 61;
		miscompares = 0;
		tests_run = 0;
		{rst_b, supply_below_threshold, master_clear_pin_in, power_up_timer_fuse} = 4'h0;
		{external_clock_mode, two_speed_fuse, fail_safe_fuse, sleep_active} = 4'h0;
		{sleep_cmd, watchdog_timer_fire, clear_wdt_cmd, soft_brown_out_wr} = 4'h0;
		{soft_brown_out_wdata, power_on_flag_set, brown_out_flag_set, prog_mode_req} = 4'h0;
		{ctrl_wr, retain_wr} = 2'h0;
		{power_on_detect, reset_pin_select_fuse} = 2'h3;
		brown_out_mode_fuses = 2'h3;
		ctrl_wdata = 8'h00;
		retain_wdata = 8'h00;
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		repeat (4) @(posedge clk);
		@(negedge clk) chk(seq_state, RSS_SEQ_HOLD);
		chk(power_on_flag, 1'b0);
		chk(reset_cause, RSS_CAUSE_POWER_ON);
		chk({timeout_flag, power_down_flag}, 2'h3);
		@(posedge clk) power_on_detect <= 1'b0;
		wt(0, RSS_SEQ_POWER_UP_TIMER);
		chk(n <= 2, 1'b1);
		wt(0, RSS_SEQ_OST);
		chk(n >= (PW - 1) * 4 && n <= PW * 4 + 2, 1'b1);
		wt(0, RSS_SEQ_RUN);
		chk(n >= (OS - 1) * 2 && n <= OS * 2 + 2, 1'b1);
		chk(chip_reset, 1'b1);
		@(posedge clk) master_clear_pin_in <= 1'b1;
		wt(1, RSS_SEQ_RUN);
		chk(n <= PF + 4, 1'b1);
		@(posedge clk) begin
			{power_on_flag_set, brown_out_flag_set, ctrl_wr, retain_wr} <= 4'hf;
			ctrl_wdata <= 8'($random(seed));
			retain_wdata <= 8'($random(seed));
		end
		@(posedge clk) {power_on_flag_set, brown_out_flag_set, ctrl_wr, retain_wr} <= 4'h0;
		@(negedge clk) chk({power_on_flag, brown_out_flag}, 2'h3);
		chk(ctrl_q, ctrl_wdata);
		chk(retain_q, retain_wdata);
		@(posedge clk) watchdog_timer_fire <= 1'b1;
		@(posedge clk) watchdog_timer_fire <= 1'b0;
		repeat (3) @(negedge clk);
		chk(seq_state, RSS_SEQ_RUN);
		chk(ctrl_q, 8'h00);
		chk(retain_q, retain_wdata);
		chk({power_on_flag, master_clear_pin_oe, master_clear_pin_out}, 3'h4);
		@(posedge clk) clear_wdt_cmd <= 1'b1;
		@(posedge clk) clear_wdt_cmd <= 1'b0;
		@(negedge clk) chk({timeout_flag, power_down_flag}, 2'h3);
		@(posedge clk) begin
			{sleep_cmd, sleep_active, ctrl_wr} <= 3'h7;
			ctrl_wdata <= 8'($random(seed));
		end
		@(posedge clk) {sleep_cmd, ctrl_wr, watchdog_timer_fire} <= 3'h1;
		@(posedge clk) watchdog_timer_fire <= 1'b0;
		@(negedge clk) chk(ctrl_q, ctrl_wdata);
		@(posedge clk) master_clear_pin_in <= 1'b0;
		repeat (PF + 3) @(posedge clk);
		@(negedge clk) chk(chip_reset, 1'b1);
		chk(reset_cause, RSS_CAUSE_PIN_SLEEP);
		chk({timeout_flag, power_down_flag, ctrl_q}, 10'h200);
		@(posedge clk) {master_clear_pin_in, sleep_active} <= 2'h2;
		wt(1, RSS_SEQ_RUN);
		chk(seq_state, RSS_SEQ_RUN);
		@(posedge clk) master_clear_pin_in <= 1'b0;
		repeat (PF - 1) @(posedge clk);
		master_clear_pin_in <= 1'b1;
		repeat (PF + 3) @(negedge clk) chk(chip_reset, 1'b0);
		@(posedge clk) supply_below_threshold <= 1'b1;
		@(posedge clk) supply_below_threshold <= 1'b0;
		repeat (4) @(negedge clk) chk(chip_reset, 1'b0);
		@(posedge clk) supply_below_threshold <= 1'b1;
		repeat (5) @(posedge clk);
		@(negedge clk) chk(seq_state, RSS_SEQ_HOLD);
		chk({reset_cause, brown_out_flag}, {RSS_CAUSE_BROWN_OUT, 1'b0});
		@(posedge clk) supply_below_threshold <= 1'b0;
		wt(0, RSS_SEQ_POWER_UP_TIMER);
		repeat (10) @(posedge clk);
		supply_below_threshold <= 1'b1;
		repeat (4) @(posedge clk);
		@(negedge clk) chk(seq_state, RSS_SEQ_HOLD);
		@(posedge clk) supply_below_threshold <= 1'b0;
		wt(0, RSS_SEQ_POWER_UP_TIMER);
		wt(0, RSS_SEQ_OST);
		chk(n >= (PW - 1) * 4 && n <= PW * 4 + 2, 1'b1);
		wt(1, RSS_SEQ_RUN);
		for (int i = 0; i < 16; i++) begin
			@(posedge clk) begin
				brown_out_mode_fuses <= i[3:2];
				{soft_brown_out_wr, soft_brown_out_wdata, sleep_active} <= {1'b1, i[1], i[0]};
			end
			@(posedge clk) soft_brown_out_wr <= 1'b0;
			@(posedge clk);
			@(negedge clk) chk(brown_out_detect_en, eb(i[3:2], i[1], i[0]));
			chk(soft_brown_out_enable, i[1]);
		end
		@(posedge clk) begin
			{reset_pin_select_fuse, master_clear_pin_in, prog_mode_req, sleep_active} <= 4'h2;
			brown_out_mode_fuses <= 2'h3;
		end
		repeat (PF + 4) @(negedge clk) chk(chip_reset, 1'b0);
		chk({pin_digital_in, pin_pullup_en, prog_mode}, 3'h1);
		@(posedge clk) master_clear_pin_in <= 1'b1;
		repeat (2) @(negedge clk);
		chk(pin_digital_in, 1'b1);
		@(posedge clk) {rst_b, power_on_detect, external_clock_mode, power_up_timer_fuse} <= 4'h7;
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk) power_on_detect <= 1'b0;
		wt(1, RSS_SEQ_RUN);
		chk(n <= 3, 1'b1);
		chk(retain_q, retain_wdata);
		@(posedge clk) {power_on_detect, external_clock_mode, two_speed_fuse} <= 3'h5;
		@(posedge clk) power_on_detect <= 1'b0;
		@(negedge clk);
		wt(1, RSS_SEQ_RUN);
		chk(seq_state, RSS_SEQ_OST);
		summarize();
	end
endmodule
